// ### pcp_cfg.svh
`ifndef PCP_CFG_SVH
`define PCP_CFG_SVH
// How it works
// - mode 0: power-on level high runs, low stops
// - mode 1: falling edge on, 4 s low off
// - short press wakes from off or Sleep
// - short press in Run/Standby only interrupts
// - long-press turn-off needs its enable bit
// - mode 1: both debounced edges raise the interrupt
// - default debounce 31.25 ms both edges
// - debounce select stretches falling edge only
// - interrupt holds until cleared or off
// - standby = pin level xor invert bit
// - hold-off delays standby entry response
// - three extra slow-clock syncing cycles
// - reset released after start, asserted at off
// - fault mode: start fault keeps reset low
// - fault mode: 1.8 ms fault asserts reset
// - fault mode: 100 ms fault turns off
// - fault mode only with enable bit set
// - release delay 2 ms to 1024 ms

// clock rates
`define PCP_CLK_HZ       200000000
`define PCP_TICK_HZ      32768
// debounce, long press and fault times as printed
`define PCP_DB_SHORT_US  31250
`define PCP_DB_MID_MS    125
`define PCP_DB_LONG_MS   750
`define PCP_LP_MS        4000
`define PCP_FLT_RST_US   1800
`define PCP_FLT_OFF_MS   100
// least times in ticks, rounded up
`define PCP_US2TK(t)     (((t) * `PCP_TICK_HZ + 999999) / 1000000)
`define PCP_MS2TK(t)     (((t) * `PCP_TICK_HZ + 999) / 1000)
`define PCP_DB_SHORT_TK  `PCP_US2TK(`PCP_DB_SHORT_US)
`define PCP_DB_MID_TK    `PCP_MS2TK(`PCP_DB_MID_MS)
`define PCP_DB_LONG_TK   `PCP_MS2TK(`PCP_DB_LONG_MS)
`define PCP_LP_TK        `PCP_MS2TK(`PCP_LP_MS)
`define PCP_FLT_RST_TK   `PCP_US2TK(`PCP_FLT_RST_US)
`define PCP_FLT_OFF_TK   `PCP_MS2TK(`PCP_FLT_OFF_MS)
// reset release delays per select code, in ms
`define PCP_REL0_MS      2
`define PCP_REL1_MS      4
`define PCP_REL2_MS      8
`define PCP_REL3_MS      16
`define PCP_REL4_MS      32
`define PCP_REL5_MS      64
`define PCP_REL6_MS      256
`define PCP_REL7_MS      1024
// standby hold-off per select code, in ms
`define PCP_SBY1_MS      1
`define PCP_SBY2_MS      2
`define PCP_SBY3_MS      4
// state reset values
`define PCP_RST_HOST_DRIVE 1'b1
`endif

// ### pcp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcp_host_model (
  input  wire logic                clk,       // system clock
  input  wire logic                rst_n,     // async reset, active low
  input  wire pcp_pkg::pcp_state_e pmState,   // device power state
  input  wire logic                idleLvl,   // pin level with button released
  input  wire logic                press,     // button held down
  input  wire logic                sbyReq,    // host asks for standby
  input  wire logic                sbyInv,    // pin polarity the host uses
  output logic                     powerOnIn, // power-on pin
  output logic                     standbyIn, // standby pin
  output logic                     seqDone    // last regulator up
);
  logic [3:0] seqCnt; // start-up progress count

  // button shorts the pin low while held
  assign powerOnIn = press ? 1'b0 : idleLvl;
  // request held until the host has finished its work
  assign standbyIn = sbyReq ^ sbyInv;
  // supplies report up a few cycles into start-up
  assign seqDone = (seqCnt >= 4'h8);

  // counts clocks spent in start-up, clears elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqCnt <= 4'h0;
    end else if (pmState != pcp_pkg::PCP_START) begin
      seqCnt <= 4'h0;
    end else if (seqCnt != 4'hF) begin
      seqCnt <= seqCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### pcp_pkg.sv
`default_nettype none
package pcp_pkg;
  // power states of the device
  typedef enum logic [2:0] {
    PCP_OFF, PCP_START, PCP_RELDLY, PCP_RUN, PCP_STBY, PCP_SLEEP
  } pcp_state_e;

  // static configuration bits
  typedef struct packed {
    logic       powerOnModeSel;        // 0 level, 1 edge
    logic       longPressOffEnable;    // long press may turn off
    logic [1:0] powerOnDebounceSel;    // falling-edge debounce
    logic       standbyPolarityInvert; // standby pin polarity
    logic [1:0] standbyHoldoffSel;     // standby hold-off code
    logic       faultResetModeEnable;  // fault supervision mode
    logic [2:0] resetReleaseDelaySel;  // reset release delay
    logic       offToSleep;            // off request goes to sleep
  } pcp_cfg_s;

  // whole state of the block
  typedef struct packed {
    pcp_state_e  state;        // power state
    logic [12:0] divCnt;       // slow tick divider
    logic        pwrPin;       // sampled power-on pin
    logic        dbLevel;      // debounced power-on level
    logic [14:0] dbCnt;        // debounce counter
    logic [17:0] lpCnt;        // long press counter
    logic [2:0]  sbySync;      // standby sync chain
    logic [7:0]  sbyCnt;       // standby delay counter
    logic [11:0] fltCnt;       // fault persistence counter
    logic        startFault;   // fault seen during start-up
    logic [15:0] relCnt;       // reset release counter
    logic        irq;          // power-on interrupt flag
    logic        hostRstDrive; // host reset pulled low
  } pcp_regs_s;
endpackage
`default_nettype wire

// ### pcp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcp_cfg.svh"
module pcp_top #(
  parameter int TICK_DIV = `PCP_CLK_HZ / `PCP_TICK_HZ  // clk cycles per slow tick
) (
  input  wire logic             clk,          // 200 MHz clock
  input  wire logic             rst_n,        // async reset, active low
  input  wire logic             clkEn,        // freezes state when low
  input  wire pcp_pkg::pcp_cfg_s cfg,         // configuration bits
  input  wire logic             powerOnIn,    // power-on input pin
  input  wire logic             standbyIn,    // standby input pin
  input  wire logic             faultIn,      // supply fault present
  input  wire logic             seqDone,      // last regulator is up
  input  wire logic             irqClear,     // write-one clear pulse
  output var  pcp_pkg::pcp_state_e pmState,   // power state
  output logic                  powerOnIrq,   // power-on interrupt flag
  output logic                  hostResetOut, // host reset drive level
  output logic                  hostResetOe   // high while pulling low
);
  pcp_pkg::pcp_regs_s r;        // registered state
  pcp_pkg::pcp_regs_s n;        // next state
  logic               tick;     // one slow clock tick
  logic               fallEv;   // debounced falling edge
  logic               riseEv;   // debounced rising edge
  logic               longEv;   // long press reached
  logic               sbyDue;   // standby request served
  logic               fltRst;   // fault asserts reset
  logic               fltOff;   // fault turns off
  logic               turnOn;   // turn-on request
  logic               offReq;   // turn-off or sleep request
  logic [7:0]         sbyLimit; // hold-off in ticks

  // falling uses the select, rising always the short figure
  function automatic logic [14:0] dbLimit(input logic rising, input logic [1:0] sel);
    if (rising || !sel[1])
      return 15'(`PCP_DB_SHORT_TK);
    else if (!sel[0])
      return 15'(`PCP_DB_MID_TK);
    else
      return 15'(`PCP_DB_LONG_TK);
  endfunction

  // release delay from the 3-bit select
  function automatic logic [15:0] relLimit(input logic [2:0] sel);
    case (sel)
      3'h0: return 16'(`PCP_MS2TK(`PCP_REL0_MS));
      3'h1: return 16'(`PCP_MS2TK(`PCP_REL1_MS));
      3'h2: return 16'(`PCP_MS2TK(`PCP_REL2_MS));
      3'h3: return 16'(`PCP_MS2TK(`PCP_REL3_MS));
      3'h4: return 16'(`PCP_MS2TK(`PCP_REL4_MS));
      3'h5: return 16'(`PCP_MS2TK(`PCP_REL5_MS));
      3'h6: return 16'(`PCP_MS2TK(`PCP_REL6_MS));
      default: return 16'(`PCP_MS2TK(`PCP_REL7_MS));
    endcase
  endfunction

  // hold-off select to ticks, zero when disabled
  always_comb begin
    case (cfg.standbyHoldoffSel)
      2'h1: sbyLimit = 8'(`PCP_MS2TK(`PCP_SBY1_MS));
      2'h2: sbyLimit = 8'(`PCP_MS2TK(`PCP_SBY2_MS));
      2'h3: sbyLimit = 8'(`PCP_MS2TK(`PCP_SBY3_MS));
      default: sbyLimit = 8'h00;
    endcase
  end

  // next-state logic
  always_comb begin
    n = r;
    fallEv = 1'b0;
    riseEv = 1'b0;
    longEv = 1'b0;
    tick = (r.divCnt == 13'(TICK_DIV - 1));
    // slow tick divider
    if (tick) begin
      n.divCnt = 13'h0;
    end else begin
      n.divCnt = r.divCnt + 13'h1;
    end
    n.pwrPin = powerOnIn;
    if (tick) begin
      // debounce of both power-on edges
      if (r.pwrPin == r.dbLevel) begin
        n.dbCnt = 15'h0;
      end else if (r.dbCnt >= dbLimit(r.pwrPin, cfg.powerOnDebounceSel) - 15'h1) begin
        n.dbCnt = 15'h0;
        n.dbLevel = r.pwrPin;
        fallEv = !r.pwrPin;
        riseEv = r.pwrPin;
      end else begin
        n.dbCnt = r.dbCnt + 15'h1;
      end
      // long press while the debounced level is low
      if (r.dbLevel) begin
        n.lpCnt = 18'h0;
      end else if (r.lpCnt != 18'(`PCP_LP_TK)) begin
        n.lpCnt = r.lpCnt + 18'h1;
        longEv = (r.lpCnt == 18'(`PCP_LP_TK - 1));
      end
      // polarity then three slow-clock sync stages
      n.sbySync = {r.sbySync[1:0], standbyIn ^ cfg.standbyPolarityInvert};
      // standby delay counter runs while a request stands
      if (!r.sbySync[2]) begin
        n.sbyCnt = 8'h0;
      end else if (r.sbyCnt < sbyLimit) begin
        n.sbyCnt = r.sbyCnt + 8'h1;
      end
      // fault persistence
      if (!faultIn) begin
        n.fltCnt = 12'h0;
      end else if (r.fltCnt != 12'(`PCP_FLT_OFF_TK)) begin
        n.fltCnt = r.fltCnt + 12'h1;
      end
      // reset release delay
      if (r.state == pcp_pkg::PCP_RELDLY && r.relCnt != 16'hFFFF) begin
        n.relCnt = r.relCnt + 16'h1;
      end
    end
    sbyDue = r.sbySync[2] && (r.sbyCnt >= sbyLimit);
    fltRst = cfg.faultResetModeEnable && (r.fltCnt >= 12'(`PCP_FLT_RST_TK));
    fltOff = cfg.faultResetModeEnable && (r.fltCnt == 12'(`PCP_FLT_OFF_TK));
    // level mode follows the level, edge mode the press
    turnOn = cfg.powerOnModeSel ? fallEv : r.dbLevel;
    offReq = fltOff || (cfg.powerOnModeSel ?
             (longEv && cfg.longPressOffEnable) : !r.dbLevel);
    // power state machine
    case (r.state)
      pcp_pkg::PCP_OFF: begin
        // fault and release counters start afresh for each start-up
        n.fltCnt = 12'h0;
        n.relCnt = 16'h0;
        n.startFault = 1'b0;
        if (turnOn) begin
          n.state = pcp_pkg::PCP_START;
        end
      end
      pcp_pkg::PCP_START: begin
        if (offReq) begin
          n.state = pcp_pkg::PCP_OFF;
        end else if (seqDone) begin
          n.state = pcp_pkg::PCP_RELDLY;
        end
      end
      pcp_pkg::PCP_RELDLY: begin
        if (offReq) begin
          n.state = pcp_pkg::PCP_OFF;
        end else if (r.relCnt >= relLimit(cfg.resetReleaseDelaySel)) begin
          n.state = pcp_pkg::PCP_RUN;
        end
      end
      pcp_pkg::PCP_RUN, pcp_pkg::PCP_STBY: begin
        // short presses here leave the power state unchanged
        if (offReq) begin
          n.state = (cfg.offToSleep && !fltOff) ? pcp_pkg::PCP_SLEEP : pcp_pkg::PCP_OFF;
        end else if (r.state == pcp_pkg::PCP_RUN && sbyDue) begin
          n.state = pcp_pkg::PCP_STBY;
        end else if (r.state == pcp_pkg::PCP_STBY && !r.sbySync[2]) begin
          n.state = pcp_pkg::PCP_RUN;
        end
      end
      pcp_pkg::PCP_SLEEP: begin
        if (fltOff) begin
          n.state = pcp_pkg::PCP_OFF;
        end else if (turnOn) begin
          n.state = pcp_pkg::PCP_RUN;
        end
      end
      default: begin
        n.state = pcp_pkg::PCP_OFF;
      end
    endcase
    // note a fault during start-up
    if ((r.state == pcp_pkg::PCP_START || r.state == pcp_pkg::PCP_RELDLY) && faultIn) begin
      n.startFault = 1'b1;
    end
    // interrupt flag: off clears, set wins over clear
    if (n.state == pcp_pkg::PCP_OFF) begin
      n.irq = 1'b0;
    end else if (cfg.powerOnModeSel && (fallEv || riseEv)) begin
      n.irq = 1'b1;
    end else if (irqClear) begin
      n.irq = 1'b0;
    end
    // host reset low until released, or on fault
    n.hostRstDrive = (n.state == pcp_pkg::PCP_OFF) || (n.state == pcp_pkg::PCP_START) ||
                     (n.state == pcp_pkg::PCP_RELDLY) ||
                     (cfg.faultResetModeEnable && (n.startFault || fltRst));
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.hostRstDrive <= `PCP_RST_HOST_DRIVE;
    end else if (clkEn) begin
      r <= n;
    end
  end

  // outputs straight from the state register, except the constant reset level
  assign pmState = r.state;
  assign powerOnIrq = r.irq;
  assign hostResetOe = r.hostRstDrive;
  assign hostResetOut = 1'b0; // open drain only ever pulls low

  // level mode turns on from off when the level is high
  chk_level_turn_on: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !cfg.powerOnModeSel && r.state == pcp_pkg::PCP_OFF && r.dbLevel
    |=> r.state == pcp_pkg::PCP_START)
    else $error("level high did not start up");

  // edge mode wakes from sleep on a press
  chk_edge_wake: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.powerOnModeSel && fallEv && !fltOff && r.state == pcp_pkg::PCP_SLEEP
    |=> r.state == pcp_pkg::PCP_RUN)
    else $error("press did not wake from sleep");

  // press in run only raises the flag
  chk_run_press: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.powerOnModeSel && fallEv && r.state == pcp_pkg::PCP_RUN && !offReq
    |=> r.irq && r.state != pcp_pkg::PCP_OFF && r.state != pcp_pkg::PCP_SLEEP)
    else $error("press in run changed power state");

  // long press without enable keeps running
  chk_long_gate: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.powerOnModeSel && !cfg.longPressOffEnable && longEv && !fltOff &&
    r.state == pcp_pkg::PCP_RUN
    |=> r.state == pcp_pkg::PCP_RUN || r.state == pcp_pkg::PCP_STBY)
    else $error("long press turned off while disabled");

  // flag stays set until clear or off
  chk_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && r.irq && !irqClear && n.state != pcp_pkg::PCP_OFF |=> r.irq)
    else $error("interrupt flag dropped by itself");

  // no standby before the hold-off has run out
  chk_sby_holdoff: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && r.state == pcp_pkg::PCP_RUN && r.sbyCnt < sbyLimit
    |=> r.state != pcp_pkg::PCP_STBY)
    else $error("standby entered before hold-off");

  // reset is held while off or starting
  chk_rst_off: assert property (@(posedge clk) disable iff (!rst_n)
    r.state inside {pcp_pkg::PCP_OFF, pcp_pkg::PCP_START, pcp_pkg::PCP_RELDLY}
    |-> hostResetOe)
    else $error("host reset released before run");

  // persistent fault pulls reset low in fault mode
  chk_fault_rst: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.faultResetModeEnable && r.fltCnt >= 12'(`PCP_FLT_RST_TK)
    |=> hostResetOe)
    else $error("fault did not assert host reset");

  // long fault turns the device off
  chk_fault_off: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && fltOff && r.state != pcp_pkg::PCP_OFF |=> r.state == pcp_pkg::PCP_OFF)
    else $error("fault did not turn device off");

  // flag is never set while off
  chk_irq_off_clear: assert property (@(posedge clk) disable iff (!rst_n)
    r.state == pcp_pkg::PCP_OFF |-> !powerOnIrq)
    else $error("interrupt flag set while off");

  // debounced edges in edge mode set the flag
  chk_edge_irq_set: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.powerOnModeSel && (fallEv || riseEv) && n.state != pcp_pkg::PCP_OFF
    |=> powerOnIrq)
    else $error("edge did not set interrupt flag");

  // level mode never raises the flag
  chk_level_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !cfg.powerOnModeSel && !r.irq |=> !powerOnIrq)
    else $error("flag raised in level mode");

  // served standby request moves run to standby
  chk_sby_enter: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && r.state == pcp_pkg::PCP_RUN && sbyDue && !offReq
    |=> r.state == pcp_pkg::PCP_STBY)
    else $error("standby request not served");

  // standby ends once the synced request drops
  chk_sby_exit: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && r.state == pcp_pkg::PCP_STBY && !r.sbySync[2] && !offReq
    |=> r.state == pcp_pkg::PCP_RUN)
    else $error("standby did not end");

  // no run before the release delay has passed
  chk_rel_wait: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && r.state == pcp_pkg::PCP_RELDLY &&
    r.relCnt < relLimit(cfg.resetReleaseDelaySel)
    |=> r.state != pcp_pkg::PCP_RUN)
    else $error("host reset released too early");

  // default mode holds reset only while off or starting
  chk_no_fault_rst: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && !cfg.faultResetModeEnable && n.state != pcp_pkg::PCP_OFF &&
    n.state != pcp_pkg::PCP_START && n.state != pcp_pkg::PCP_RELDLY
    |=> !hostResetOe)
    else $error("host reset held outside fault mode");

  // fault seen during start-up keeps reset low
  chk_start_fault: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn && cfg.faultResetModeEnable && n.startFault |=> hostResetOe)
    else $error("start-up fault did not hold reset");
endmodule
`default_nettype wire

// ### pcp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pcp_top_tb;
  localparam int TD = 2; // clk cycles per slow tick
  logic                clk, rst_n, clkEn, faultIn, irqClear;  // design inputs
  logic                idleLvl, press, sbyReq, sbyInv;         // model controls
  logic                powerOnIn, standbyIn, seqDone;          // model outputs
  logic                powerOnIrq, hostResetOut, hostResetOe;  // design outputs
  pcp_pkg::pcp_cfg_s   cfg;                                    // configuration
  pcp_pkg::pcp_state_e pmState;                                // power state
  int                  num_errors, n_compared, cycles, seed, rel; // bookkeeping

  pcp_top #(.TICK_DIV(TD)) pcp_top_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .cfg(cfg),
    .powerOnIn(powerOnIn), .standbyIn(standbyIn), .faultIn(faultIn), .seqDone(seqDone),
    .irqClear(irqClear), .pmState(pmState), .powerOnIrq(powerOnIrq),
    .hostResetOut(hostResetOut), .hostResetOe(hostResetOe));
  pcp_host_model pcp_host_model_i (.clk(clk), .rst_n(rst_n), .pmState(pmState),
    .idleLvl(idleLvl), .press(press), .sbyReq(sbyReq), .sbyInv(sbyInv),
    .powerOnIn(powerOnIn), .standbyIn(standbyIn), .seqDone(seqDone));

  // clock generator
  always #2.5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      final_report();
    end
  end

  // release delay in ticks for the codes used here
  function automatic int relTk(input logic [2:0] sel);
    return (sel == 3'h0) ? 66 : (sel == 3'h1) ? 132 : 263;
  endfunction
  // state expected from pin level and polarity
  function automatic pcp_pkg::pcp_state_e stExp(input logic pin, input logic inv);
    return (pin ^ inv) ? pcp_pkg::PCP_STBY : pcp_pkg::PCP_RUN;
  endfunction

  // wait n ticks, then step off the edge
  task automatic tk(input int n);
    repeat (n * TD) @(posedge clk);
    #1;
  endtask
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chkSt(input pcp_pkg::pcp_state_e e);
    chk(8'(pmState), 8'(e));
  endtask
  task automatic chkOe(input logic e);
    chk(8'(hostResetOe), 8'(e));
  endtask
  task automatic chkIrq(input logic e);
    chk(8'(powerOnIrq), 8'(e));
  endtask
  // software write-one clear, one slow tick
  task automatic clr();
    irqClear = 1'b1;
    tk(1);
    irqClear = 1'b0;
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 32'h99F1;
    {clk, rst_n, faultIn, irqClear, idleLvl, press, sbyReq} = 7'h00;
    clkEn = 1'b1;
    cfg = '0;
    sbyInv = 1'($random(seed));
    cfg.standbyPolarityInvert = sbyInv;
    cfg.resetReleaseDelaySel = 3'($unsigned($random(seed)) % 3);
    rel = relTk(cfg.resetReleaseDelaySel);
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    chkSt(pcp_pkg::PCP_OFF);
    chkOe(1'b1);
    chk(8'(hostResetOut), 8'h00);
    // level mode turn-on through release delay
    idleLvl = 1'b1;
    tk(1000);
    chkSt(pcp_pkg::PCP_OFF);
    tk(rel + 25);
    chkOe(1'b1);
    tk(30);
    chkSt(pcp_pkg::PCP_RUN);
    chkOe(1'b0);
    // standby with and without hold-off
    for (int h = 0; h < 2; h++) begin
      cfg.standbyHoldoffSel = 2'(h);
      sbyReq = 1'b1;
      tk(h * 25 + 1);
      chkSt(pcp_pkg::PCP_RUN);
      tk(h * 20 + 10);
      chkSt(stExp(standbyIn, sbyInv));
      sbyReq = 1'b0;
      tk(10);
      chkSt(stExp(standbyIn, sbyInv));
    end
    // fault ignored outside fault mode
    faultIn = 1'b1;
    tk(80);
    chkOe(1'b0);
    faultIn = 1'b0;
    // level low turns off
    idleLvl = 1'b0;
    tk(1040);
    chkSt(pcp_pkg::PCP_OFF);
    chkOe(1'b1);
    // edge mode: rise in off does nothing
    cfg.powerOnModeSel = 1'b1;
    idleLvl = 1'b1;
    tk(1100);
    chkSt(pcp_pkg::PCP_OFF);
    chkIrq(1'b0);
    press = 1'b1;
    tk(1100);
    press = 1'b0;
    tk(1100 + rel);
    chkSt(pcp_pkg::PCP_RUN);
    chkIrq(1'b1);
    clr();
    chkIrq(1'b0);
    // glitch shorter than debounce
    press = 1'b1;
    tk(100 + $unsigned($random(seed)) % 800);
    press = 1'b0;
    tk(1100);
    chkIrq(1'b0);
    // short press in run only flags
    for (int d = 0; d < 2; d++) begin
      cfg.powerOnDebounceSel = 2'(d * 2);
      press = 1'b1;
      tk(2000);
      chkIrq(d == 0);
      tk(2200);
      chkIrq(1'b1);
      chkSt(pcp_pkg::PCP_RUN);
      clr();
      press = 1'b0;
      tk(1100);
      chkIrq(1'b1);
      clr();
    end
    // level low with sleep chosen, then edge wake after a clock hold
    cfg.powerOnDebounceSel = 2'h0;
    cfg.powerOnModeSel = 1'b0;
    cfg.offToSleep = 1'b1;
    idleLvl = 1'b0;
    tk(1040);
    chkSt(pcp_pkg::PCP_SLEEP);
    chkOe(1'b0);
    cfg.powerOnModeSel = 1'b1;
    idleLvl = 1'b1;
    tk(1040);
    chkSt(pcp_pkg::PCP_SLEEP);
    chkIrq(1'b1);
    clkEn = 1'b0;
    press = 1'b1;
    tk(1100);
    chkSt(pcp_pkg::PCP_SLEEP);
    clkEn = 1'b1;
    tk(1040);
    chkSt(pcp_pkg::PCP_RUN);
    press = 1'b0;
    tk(1040);
    clr();
    chkIrq(1'b0);
    cfg.offToSleep = 1'b0;
    // fault mode: reset assert, then turn-off
    cfg.faultResetModeEnable = 1'b1;
    faultIn = 1'b1;
    tk(50);
    chkOe(1'b0);
    tk(15);
    chkOe(1'b1);
    faultIn = 1'b0;
    tk(3);
    chkOe(1'b0);
    faultIn = 1'b1;
    tk(3265);
    chkSt(pcp_pkg::PCP_RUN);
    tk(20);
    chkSt(pcp_pkg::PCP_OFF);
    faultIn = 1'b0;
    // restart with fault during start-up keeps reset
    press = 1'b1;
    tk(1030);
    faultIn = 1'b1;
    tk(10);
    faultIn = 1'b0;
    tk(60);
    press = 1'b0;
    tk(rel + 100);
    chkSt(pcp_pkg::PCP_RUN);
    chkOe(1'b1);
    final_report();
  end
endmodule
`default_nettype wire
